// file: rtl/fcvrp_regs.svh
// Register offsets, field positions, reset values and command codes of the flash command sequencer.
`ifndef FCVRP_REGS_SVH
`define FCVRP_REGS_SVH
`define FCVRP_OFS_STATUS 8'h00
`define FCVRP_OFS_INDEX 8'h04
`define FCVRP_OFS_WORD 8'h08
`define FCVRP_OFS_MODE 8'h0C
`define FCVRP_OFS_PROT 8'h10
`define FCVRP_ST_COMPLETE 7
`define FCVRP_ST_ACCESS_ERR 5
`define FCVRP_ST_PROT_VIOL 4
`define FCVRP_ST_MG1 1
`define FCVRP_ST_MG0 0
`define FCVRP_PROT_EN 31
`define FCVRP_MODE_RST 3'h7
`define FCVRP_MODE_BLANK 0
`define FCVRP_MODE_ONCE 1
`define FCVRP_MODE_PROG 2
`define FCVRP_CMD_BLANK 8'h03
`define FCVRP_CMD_ONCE 8'h04
`define FCVRP_CMD_PROG 8'h06
`define FCVRP_IDX_BLANK 3'h2
`define FCVRP_IDX_ONCE 3'h1
`define FCVRP_IDX_PROG 3'h5
`define FCVRP_ONCE_MAX 16'h0007
`define FCVRP_PHRASE_BYTES 21'h000008
`define FCVRP_RESP_OKAY 2'h0
`define FCVRP_RESP_SLVERR 2'h2
`endif

// file: rtl/fcvrp_pkg.sv
// Types shared by the flash command sequencer.
`default_nettype none
package fcvrp_pkg;
   typedef enum logic [2:0] {
      FCVRP_IDLE = 3'b000,
      FCVRP_CHECK = 3'b001,
      FCVRP_REQ = 3'b010,
      FCVRP_WAIT = 3'b011,
      FCVRP_DONE = 3'b100
   } fcvrp_state_t;
   typedef enum logic [1:0] {
      FCVRP_OP_NONE = 2'b00,
      FCVRP_OP_BLANK = 2'b01,
      FCVRP_OP_ONCE = 2'b10,
      FCVRP_OP_PROG = 2'b11
   } fcvrp_op_t;
endpackage : fcvrp_pkg
`default_nettype wire

// file: rtl/fcvrp_top.sv
// Flash command sequencer for section blank-check, once-field read and phrase program.
`include "fcvrp_regs.svh"
`default_nettype none
module fcvrp_top #(
   parameter logic [20:0] FLASH_BYTES = 21'h040000
) (
   // Clock and reset.
   input wire logic CLOCK,
   input wire logic RST,
   // AXI4-Lite write address and data.
   input wire logic [7:0] AWADDR,
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   output logic WREADY,
   // AXI4-Lite write response.
   output logic [1:0] BRESP,
   output logic BVALID,
   input wire logic BREADY,
   // AXI4-Lite read.
   input wire logic [7:0] ARADDR,
   input wire logic ARVALID,
   output logic ARREADY,
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   output logic RVALID,
   input wire logic RREADY,
   // Flash array port.
   output logic FLASH_REQ,
   output logic FLASH_WE,
   output logic FLASH_INFO,
   output logic [17:0] FLASH_ADDR,
   output logic [63:0] FLASH_WDATA,
   input wire logic FLASH_ACK,
   input wire logic [63:0] FLASH_RDATA,
   input wire logic FLASH_ECC_ANY,
   input wire logic FLASH_ECC_FATAL,
   // Status toward the processor read path.
   output logic PFLASH_READ_INVALID,
   output logic BUSY
);
   import fcvrp_pkg::*;

   fcvrp_state_t state;
   fcvrp_op_t op;
   logic cmd_complete_flag;
   logic access_error_flag;
   logic protection_violation_flag;
   logic read_status_any_error;
   logic read_status_uncorrectable;
   logic [2:0] cmd_object_index;
   logic [15:0] cmd_object_word [0:5];
   logic [2:0] mode_allow;
   logic [31:0] prot;
   logic [17:0] cur_addr;
   logic [15:0] left;
   logic writing;
   logic aw_have;
   logic w_have;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic wr_fire;
   logic wr_hit;
   logic launch;
   logic [7:0] cmd_code;
   logic [17:0] cmd_addr;
   logic [20:0] range_end;
   logic set_acc;
   logic set_prot;
   logic set_mg1;
   logic set_mg0;

   // True when the phrase address lies inside the program flash.
   function automatic logic addr_ok(input logic [17:0] a);
      addr_ok = ({3'h0, a} < FLASH_BYTES);
   endfunction : addr_ok

   // True when a write offset is a mapped register.
   function automatic logic reg_hit(input logic [7:0] a);
      reg_hit = (a == `FCVRP_OFS_STATUS) || (a == `FCVRP_OFS_INDEX) || (a == `FCVRP_OFS_WORD) ||
                (a == `FCVRP_OFS_MODE) || (a == `FCVRP_OFS_PROT);
   endfunction : reg_hit

   assign cmd_code = cmd_object_word[0][15:8];
   assign cmd_addr = {cmd_object_word[0][1:0], cmd_object_word[1]};
   assign range_end = {3'h0, cmd_addr} + {2'h0, cmd_object_word[2], 3'h0};
   assign wr_fire = aw_have && w_have && !BVALID;
   assign wr_hit = reg_hit(aw_addr);
   assign launch = wr_fire && (aw_addr == `FCVRP_OFS_STATUS) && w_strb[0] &&
                   w_data[`FCVRP_ST_COMPLETE] && cmd_complete_flag;

   // AXI4-Lite write channels: address and data taken in either order.
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         AWREADY <= 1'b0;
         WREADY <= 1'b0;
         aw_have <= 1'b0;
         w_have <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         BVALID <= 1'b0;
         BRESP <= `FCVRP_RESP_OKAY;
      end else begin
         AWREADY <= !aw_have && !(AWVALID && AWREADY);
         WREADY <= !w_have && !(WVALID && WREADY);
         if (AWVALID && AWREADY) begin
            aw_have <= 1'b1;
            aw_addr <= AWADDR;
         end
         if (WVALID && WREADY) begin
            w_have <= 1'b1;
            w_data <= WDATA;
            w_strb <= WSTRB;
         end
         if (wr_fire) begin
            BVALID <= 1'b1;
            BRESP <= wr_hit ? `FCVRP_RESP_OKAY : `FCVRP_RESP_SLVERR;
         end
         if (BVALID && BREADY) begin
            BVALID <= 1'b0;
            aw_have <= 1'b0;
            w_have <= 1'b0;
         end
      end
   end

   // AXI4-Lite read channel: one cycle from address to data.
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         ARREADY <= 1'b0;
         RVALID <= 1'b0;
         RDATA <= 32'h0000_0000;
         RRESP <= `FCVRP_RESP_OKAY;
      end else begin
         ARREADY <= !RVALID && !(ARVALID && ARREADY);
         if (ARVALID && ARREADY) begin
            RVALID <= 1'b1;
            RRESP <= reg_hit(ARADDR) ? `FCVRP_RESP_OKAY : `FCVRP_RESP_SLVERR;
            case (ARADDR)
               `FCVRP_OFS_STATUS: RDATA <= {24'h0, cmd_complete_flag, 1'b0, access_error_flag,
                                           protection_violation_flag, 2'h0, read_status_any_error,
                                           read_status_uncorrectable};
               `FCVRP_OFS_INDEX: RDATA <= {29'h0, cmd_object_index};
               `FCVRP_OFS_WORD: RDATA <= (cmd_object_index <= 3'h5) ?
                                         {16'h0, cmd_object_word[cmd_object_index]} : 32'h0000_0000;
               `FCVRP_OFS_MODE: RDATA <= {29'h0, mode_allow};
               `FCVRP_OFS_PROT: RDATA <= prot;
               default: RDATA <= 32'h0000_0000;
            endcase
         end else if (RVALID && RREADY) begin
            RVALID <= 1'b0;
         end
      end
   end

   // Index, mode and protection registers; loading is refused while a command runs.
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         cmd_object_index <= 3'h0;
         mode_allow <= `FCVRP_MODE_RST;
         prot <= 32'h0000_0000;
      end else if (wr_fire && cmd_complete_flag) begin
         if (aw_addr == `FCVRP_OFS_INDEX && w_strb[0]) begin
            cmd_object_index <= w_data[2:0];
         end
         if (aw_addr == `FCVRP_OFS_MODE && w_strb[0]) begin
            mode_allow <= w_data[2:0];
         end
         if (aw_addr == `FCVRP_OFS_PROT) begin
            prot <= w_data;
         end
      end
   end

   // Command object words: loaded by software, filled by the once-field read.
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         for (int i = 0; i < 6; i++) begin
            cmd_object_word[i] <= 16'h0000;
         end
      end else if (state == FCVRP_WAIT && FLASH_ACK && op == FCVRP_OP_ONCE) begin
         cmd_object_word[2] <= FLASH_RDATA[63:48];
         cmd_object_word[3] <= FLASH_RDATA[47:32];
         cmd_object_word[4] <= FLASH_RDATA[31:16];
         cmd_object_word[5] <= FLASH_RDATA[15:0];
      end else if (wr_fire && cmd_complete_flag && aw_addr == `FCVRP_OFS_WORD &&
                   cmd_object_index <= 3'h5) begin
         if (w_strb[0]) begin
            cmd_object_word[cmd_object_index][7:0] <= w_data[7:0];
         end
         if (w_strb[1]) begin
            cmd_object_word[cmd_object_index][15:8] <= w_data[15:8];
         end
      end
   end

   // Parameter checks made in the cycle after launch.
   always_comb begin
      set_acc = 1'b0;
      set_prot = 1'b0;
      case (cmd_code)
         `FCVRP_CMD_BLANK: begin
            if (!mode_allow[`FCVRP_MODE_BLANK] || cmd_object_index != `FCVRP_IDX_BLANK ||
                !addr_ok(cmd_addr) || cmd_addr[2:0] != 3'h0 || range_end > FLASH_BYTES) begin
               set_acc = 1'b1;
            end
         end
         `FCVRP_CMD_ONCE: begin
            if (!mode_allow[`FCVRP_MODE_ONCE] || cmd_object_index != `FCVRP_IDX_ONCE ||
                cmd_object_word[1] > `FCVRP_ONCE_MAX) begin
               set_acc = 1'b1;
            end
         end
         `FCVRP_CMD_PROG: begin
            if (!mode_allow[`FCVRP_MODE_PROG] || cmd_object_index != `FCVRP_IDX_PROG ||
                !addr_ok(cmd_addr) || cmd_addr[2:0] != 3'h0) begin
               set_acc = 1'b1;
            end else if (prot[`FCVRP_PROT_EN] && cmd_addr >= prot[17:0]) begin
               set_prot = 1'b1;
            end
         end
         default: set_acc = 1'b1;
      endcase
   end

   // Read-status events from each completed flash read access; write accesses raise none.
   always_comb begin
      set_mg1 = 1'b0;
      set_mg0 = 1'b0;
      if (state == FCVRP_WAIT && FLASH_ACK && !writing) begin
         if (FLASH_ECC_ANY || FLASH_ECC_FATAL) begin
            set_mg1 = 1'b1;
         end
         if (FLASH_ECC_FATAL) begin
            set_mg0 = 1'b1;
         end
         if (op == FCVRP_OP_BLANK && FLASH_RDATA != 64'hFFFF_FFFF_FFFF_FFFF) begin
            set_mg1 = 1'b1;
            set_mg0 = 1'b1;
         end
         if (op == FCVRP_OP_PROG && FLASH_RDATA != FLASH_WDATA) begin
            set_mg1 = 1'b1;
         end
      end
   end

   // Command sequencer.
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         state <= FCVRP_IDLE;
         op <= FCVRP_OP_NONE;
         cur_addr <= 18'h00000;
         left <= 16'h0000;
         writing <= 1'b0;
      end else begin
         case (state)
            FCVRP_IDLE: begin
               if (launch) begin
                  state <= FCVRP_CHECK;
               end
            end
            FCVRP_CHECK: begin
               writing <= 1'b0;
               if (set_acc || set_prot) begin
                  state <= FCVRP_DONE;
               end else if (cmd_code == `FCVRP_CMD_BLANK) begin
                  op <= FCVRP_OP_BLANK;
                  cur_addr <= cmd_addr;
                  left <= cmd_object_word[2];
                  state <= (cmd_object_word[2] == 16'h0000) ? FCVRP_DONE : FCVRP_REQ;
               end else if (cmd_code == `FCVRP_CMD_ONCE) begin
                  op <= FCVRP_OP_ONCE;
                  cur_addr <= {cmd_object_word[1][14:0], 3'h0};
                  state <= FCVRP_REQ;
               end else begin
                  op <= FCVRP_OP_PROG;
                  cur_addr <= cmd_addr;
                  writing <= 1'b1;
                  state <= FCVRP_REQ;
               end
            end
            FCVRP_REQ: begin
               state <= FCVRP_WAIT;
            end
            FCVRP_WAIT: begin
               if (FLASH_ACK) begin
                  if (writing) begin
                     writing <= 1'b0;
                     state <= FCVRP_REQ;
                  end else if (op == FCVRP_OP_BLANK && left != 16'h0001) begin
                     left <= left - 16'h0001;
                     cur_addr <= cur_addr + 18'h00008;
                     state <= FCVRP_REQ;
                  end else begin
                     state <= FCVRP_DONE;
                  end
               end
            end
            FCVRP_DONE: begin
               op <= FCVRP_OP_NONE;
               state <= FCVRP_IDLE;
            end
            default: state <= FCVRP_IDLE;
         endcase
      end
   end

   // Flash port, held from request until acknowledge.
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         FLASH_REQ <= 1'b0;
         FLASH_WE <= 1'b0;
         FLASH_INFO <= 1'b0;
         FLASH_ADDR <= 18'h00000;
         FLASH_WDATA <= 64'h0000_0000_0000_0000;
      end else if (state == FCVRP_REQ) begin
         FLASH_REQ <= 1'b1;
         FLASH_WE <= writing;
         FLASH_INFO <= (op == FCVRP_OP_ONCE);
         FLASH_ADDR <= cur_addr;
         FLASH_WDATA <= {cmd_object_word[2], cmd_object_word[3], cmd_object_word[4], cmd_object_word[5]};
      end else if (FLASH_ACK) begin
         FLASH_REQ <= 1'b0;
         FLASH_WE <= 1'b0;
      end
   end

   // Status flags; a hardware set wins over a software clear in the same cycle.
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         cmd_complete_flag <= 1'b1;
         access_error_flag <= 1'b0;
         protection_violation_flag <= 1'b0;
         read_status_any_error <= 1'b0;
         read_status_uncorrectable <= 1'b0;
         PFLASH_READ_INVALID <= 1'b0;
         BUSY <= 1'b0;
      end else begin
         if (wr_fire && aw_addr == `FCVRP_OFS_STATUS && w_strb[0]) begin
            if (w_data[`FCVRP_ST_ACCESS_ERR]) begin
               access_error_flag <= 1'b0;
            end
            if (w_data[`FCVRP_ST_PROT_VIOL]) begin
               protection_violation_flag <= 1'b0;
            end
         end
         if (launch) begin
            cmd_complete_flag <= 1'b0;
            read_status_any_error <= 1'b0;
            read_status_uncorrectable <= 1'b0;
            BUSY <= 1'b1;
         end
         if (state == FCVRP_CHECK && set_acc) begin
            access_error_flag <= 1'b1;
         end
         if (state == FCVRP_CHECK && set_prot) begin
            protection_violation_flag <= 1'b1;
         end
         if (set_mg1) begin
            read_status_any_error <= 1'b1;
         end
         if (set_mg0) begin
            read_status_uncorrectable <= 1'b1;
         end
         if (state == FCVRP_CHECK && cmd_code == `FCVRP_CMD_ONCE && !set_acc) begin
            PFLASH_READ_INVALID <= 1'b1;
         end
         if (state == FCVRP_DONE) begin
            cmd_complete_flag <= 1'b1;
            PFLASH_READ_INVALID <= 1'b0;
            BUSY <= 1'b0;
         end
      end
   end
endmodule : fcvrp_top
`default_nettype wire

// file: sim/fcvrp_monitor.sv
// Port checks of the flash command sequencer, bound to its top module.
`default_nettype none
module fcvrp_monitor #(
   parameter logic [20:0] FLASH_BYTES = 21'h040000
) (
   // Clock and reset.
   input wire logic CLOCK,
   input wire logic RST,
   // Register bus answers.
   input wire logic [1:0] BRESP,
   input wire logic BVALID,
   input wire logic BREADY,
   input wire logic [31:0] RDATA,
   input wire logic RVALID,
   input wire logic RREADY,
   // Flash array port and status.
   input wire logic FLASH_REQ,
   input wire logic FLASH_WE,
   input wire logic FLASH_INFO,
   input wire logic [17:0] FLASH_ADDR,
   input wire logic FLASH_ACK,
   input wire logic PFLASH_READ_INVALID,
   input wire logic BUSY
);
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (RST);
   property p_b_hold; BVALID && !BREADY |=> BVALID && $stable(BRESP); endproperty
   a_b_hold: assert property (p_b_hold)
      else $error("Write response withdrawn early.");
   property p_r_hold; RVALID && !RREADY |=> RVALID && $stable(RDATA); endproperty
   a_r_hold: assert property (p_r_hold)
      else $error("Read data withdrawn early.");
   property p_req_hold; FLASH_REQ && !FLASH_ACK |=> FLASH_REQ && $stable(FLASH_ADDR) && $stable(FLASH_WE); endproperty
   a_req_hold: assert property (p_req_hold)
      else $error("Flash request changed before acknowledge.");
   property p_idle_no_req; !BUSY |-> !FLASH_REQ; endproperty
   a_idle_no_req: assert property (p_idle_no_req)
      else $error("Flash access while command complete.");
   property p_prog_verify; FLASH_REQ && FLASH_WE && FLASH_ACK |=> BUSY [*3]; endproperty
   a_prog_verify: assert property (p_prog_verify)
      else $error("Completion before read back.");
   property p_align; FLASH_REQ |-> FLASH_ADDR[2:0] == 3'h0; endproperty
   a_align: assert property (p_align)
      else $error("Misaligned phrase access.");
   property p_range; FLASH_REQ && !FLASH_INFO |-> {3'h0, FLASH_ADDR} + 21'h000008 <= FLASH_BYTES; endproperty
   a_range: assert property (p_range)
      else $error("Access past end of flash.");
   property p_info; FLASH_REQ && FLASH_INFO |-> !FLASH_WE && FLASH_ADDR < 18'h00040; endproperty
   a_info: assert property (p_info)
      else $error("Once field access out of its area.");
   property p_info_inv; FLASH_REQ && FLASH_INFO |-> PFLASH_READ_INVALID; endproperty
   a_info_inv: assert property (p_info_inv)
      else $error("Flash reads not marked invalid.");
   property p_inv_busy; $rose(PFLASH_READ_INVALID) |-> BUSY; endproperty
   a_inv_busy: assert property (p_inv_busy)
      else $error("Invalid marker outside a command.");
   c_prog: cover property (FLASH_REQ && FLASH_WE && FLASH_ACK);
   c_once: cover property (FLASH_REQ && FLASH_INFO && FLASH_ACK);
   c_done: cover property ($fell(BUSY));
endmodule : fcvrp_monitor
bind fcvrp_top fcvrp_monitor #(.FLASH_BYTES(FLASH_BYTES)) u_mon (.CLOCK(CLOCK), .RST(RST), .BRESP(BRESP),
   .BVALID(BVALID), .BREADY(BREADY), .RDATA(RDATA), .RVALID(RVALID), .RREADY(RREADY), .FLASH_REQ(FLASH_REQ),
   .FLASH_WE(FLASH_WE), .FLASH_INFO(FLASH_INFO), .FLASH_ADDR(FLASH_ADDR), .FLASH_ACK(FLASH_ACK),
   .PFLASH_READ_INVALID(PFLASH_READ_INVALID), .BUSY(BUSY));
`default_nettype wire

// file: sim/fcvrp_test.sv
// Self-checking bench of the flash command sequencer with a behavioural flash array.
`default_nettype none
module fcvrp_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic CLOCK = 1'b0;
   logic RST, AWVALID, WVALID, BREADY, ARVALID, RREADY, AWREADY, WREADY, BVALID, ARREADY, RVALID;
   logic [7:0] AWADDR, ARADDR;
   logic [31:0] WDATA, RDATA;
   logic [3:0] WSTRB;
   logic [1:0] BRESP, RRESP;
   logic FLASH_REQ, FLASH_WE, FLASH_INFO, PFLASH_READ_INVALID, BUSY;
   logic [17:0] FLASH_ADDR;
   logic [63:0] FLASH_WDATA;
   logic FLASH_ACK = 1'b0, FLASH_ECC_ANY = 1'b0, FLASH_ECC_FATAL = 1'b0, saw_inv = 1'b0, eany = 1'b0, efat = 1'b0;
   logic [63:0] FLASH_RDATA = 64'h0;
   logic [63:0] mem [logic [17:0]];
   int cnt = 0, lat = 1, cyc = 0, bad_count = 0, n_compared = 0;
   fcvrp_top #(.FLASH_BYTES(21'h000100)) dut (.CLOCK(CLOCK), .RST(RST), .AWADDR(AWADDR), .AWVALID(AWVALID),
      .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
      .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA),
      .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY), .FLASH_REQ(FLASH_REQ), .FLASH_WE(FLASH_WE),
      .FLASH_INFO(FLASH_INFO), .FLASH_ADDR(FLASH_ADDR), .FLASH_WDATA(FLASH_WDATA), .FLASH_ACK(FLASH_ACK),
      .FLASH_RDATA(FLASH_RDATA), .FLASH_ECC_ANY(FLASH_ECC_ANY), .FLASH_ECC_FATAL(FLASH_ECC_FATAL),
      .PFLASH_READ_INVALID(PFLASH_READ_INVALID), .BUSY(BUSY));
   always #2 CLOCK = ~CLOCK;
   // Flash array: answers lat+1 cycles after a request; the read bus toggles whenever no answer stands.
   always @(posedge CLOCK) begin
      FLASH_ACK <= 1'b0;
      FLASH_ECC_ANY <= 1'b0;
      FLASH_ECC_FATAL <= 1'b0;
      FLASH_RDATA <= ~FLASH_RDATA;
      if (PFLASH_READ_INVALID) saw_inv <= 1'b1;
      if (!FLASH_REQ || FLASH_ACK) cnt <= 0;
      else if (cnt != lat) cnt <= cnt + 1;
      else begin
         FLASH_ACK <= 1'b1;
         FLASH_ECC_ANY <= eany;
         FLASH_ECC_FATAL <= efat;
         if (FLASH_INFO) FLASH_RDATA <= 64'hC000_C100_C200_C300 | {4{13'h0, FLASH_ADDR[5:3]}};
         else FLASH_RDATA <= mem.exists(FLASH_ADDR) ? mem[FLASH_ADDR] : 64'hFFFF_FFFF_FFFF_FFFF;
         if (FLASH_WE) mem[FLASH_ADDR] = FLASH_WDATA;
      end
   end
   always @(posedge CLOCK) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         bad_count++;
         summarize();
      end
   end
   task automatic summarize();
      $display("Compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : summarize
   task automatic chk(input logic [63:0] g, input logic [63:0] e);
      n_compared++;
      if (g !== e) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge CLOCK);
      AWADDR <= a;
      WDATA <= d;
      AWVALID <= 1'b1;
      WVALID <= 1'b1;
      BREADY <= 1'b1;
      do begin
         @(posedge CLOCK);
         if (AWVALID && AWREADY) AWVALID <= 1'b0;
         if (WVALID && WREADY) WVALID <= 1'b0;
      end while (!BVALID);
      BREADY <= 1'b0;
      chk(BRESP, er);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      @(posedge CLOCK);
      ARADDR <= a;
      ARVALID <= 1'b1;
      RREADY <= 1'b1;
      do begin
         @(posedge CLOCK);
         if (ARVALID && ARREADY) ARVALID <= 1'b0;
      end while (!RVALID);
      RREADY <= 1'b0;
      chk(RRESP, er);
      if (er == 2'h0) chk(RDATA, e);
   endtask : rd
   task automatic words(input logic [63:0] v);
      for (int i = 0; i < 4; i++) begin
         wr(8'h04, 32'(i + 2), 2'h0);
         wr(8'h08, {16'h0, v[63 - 16 * i -: 16]}, 2'h0);
      end
   endtask : words
   task automatic run(input logic [15:0] w0, input logic [15:0] w1, input logic [2:0] ix, input logic [31:0] e);
      wr(8'h04, 32'h0, 2'h0);
      wr(8'h08, {16'h0, w0}, 2'h0);
      wr(8'h04, 32'h1, 2'h0);
      wr(8'h08, {16'h0, w1}, 2'h0);
      wr(8'h04, {29'h0, ix}, 2'h0);
      wr(8'h00, 32'h80, 2'h0);
      repeat (2) @(posedge CLOCK);
      while (BUSY) @(posedge CLOCK);
      rd(8'h00, e, 2'h0);
      wr(8'h00, 32'h30, 2'h0);
   endtask : run
   task automatic t_regs();
      rd(8'h00, 32'h80, 2'h0);
      rd(8'h0C, 32'h7, 2'h0);
      rd(8'h10, 32'h0, 2'h0);
      rd(8'hFC, 32'h0, 2'h2);
      wr(8'hFC, 32'h5, 2'h2);
   endtask : t_regs
   task automatic t_prog();
      words(64'h0002_0000_0000_0000);
      run(16'h0300, 16'h0010, 3'h2, 32'h80);
      lat = 4;
      words(64'h1111_2222_3333_4444);
      run(16'h0600, 16'h0010, 3'h5, 32'h80);
      chk(mem[18'h10], 64'h1111_2222_3333_4444);
      words(64'h0002_0000_0000_0000);
      run(16'h0300, 16'h0008, 3'h2, 32'h83);
      lat = 1;
   endtask : t_prog
   task automatic t_errs();
      run(16'h0300, 16'h0008, 3'h1, 32'hA0);
      run(16'h0300, 16'h00F8, 3'h2, 32'hA0);
      run(16'h0600, 16'h0011, 3'h5, 32'hA0);
      run(16'h0600, 16'h0100, 3'h5, 32'hA0);
      run(16'h0600, 16'h0020, 3'h4, 32'hA0);
      run(16'h0400, 16'h0003, 3'h2, 32'hA0);
      run(16'h0400, 16'h0008, 3'h1, 32'hA0);
      wr(8'h0C, 32'h6, 2'h0);
      run(16'h0300, 16'h0008, 3'h2, 32'hA0);
      wr(8'h0C, 32'h5, 2'h0);
      run(16'h0400, 16'h0003, 3'h1, 32'hA0);
      wr(8'h0C, 32'h3, 2'h0);
      run(16'h0600, 16'h0020, 3'h5, 32'hA0);
      wr(8'h0C, 32'h7, 2'h0);
      wr(8'h10, 32'h8000_0080, 2'h0);
      run(16'h0600, 16'h0080, 3'h5, 32'h90);
      wr(8'h10, 32'h0, 2'h0);
      chk(mem.exists(18'h20) | mem.exists(18'h80), 64'h0);
      run(16'h0500, 16'h0008, 3'h1, 32'hA0);
      words(64'h0000_0000_0000_0000);
      run(16'h0300, 16'h0008, 3'h2, 32'h80);
   endtask : t_errs
   task automatic t_once();
      lat = 4;
      run(16'h0400, 16'h0003, 3'h1, 32'h80);
      chk(saw_inv, 64'h1);
      for (int i = 0; i < 4; i++) begin
         wr(8'h04, 32'(i + 2), 2'h0);
         rd(8'h08, 32'hC003 + 32'(i * 256), 2'h0);
      end
      efat = 1'b1;
      eany = 1'b1;
      run(16'h0400, 16'h0007, 3'h1, 32'h83);
      efat = 1'b0;
      run(16'h0600, 16'h0018, 3'h5, 32'h82);
      eany = 1'b0;
   endtask : t_once
   initial begin
      RST = 1'b1;
      {AWVALID, WVALID, BREADY, ARVALID, RREADY} = 5'h00;
      AWADDR = 8'h00;
      ARADDR = 8'h00;
      WDATA = 32'h0;
      WSTRB = 4'hF;
      repeat (10) @(posedge CLOCK);
      RST <= 1'b0;
      t_regs();
      t_prog();
      t_errs();
      t_once();
      summarize();
   end
endmodule : fcvrp_test
`default_nettype wire
